// File: imcd_top.sv
// System-board ISA memory command strobes, terminal count, I/O decode and IRQ routing
// Notes on behaviour
// [R01] General memory read strobe low on every memory read cycle.
// [R02] Low-memory read strobe low only with read strobe and low 1MB address.
// [R03] General memory write strobe low on every memory write cycle.
// [R04] Low-memory write strobe low only with write strobe and low 1MB address.
// [R05] External master holds address one clock before driving read strobe.
// [R06] External master holds address one clock before driving write strobe.
// [R07] Read and write strobes are shared; release them when another master owns bus.
// [R08] All four memory strobes are active low.
// [R09] One pulse on terminal count when any DMA channel reaches its count; code pulses only on a rise of the OR of all channel flags.
// [R10] Master interrupt controller at 020-03F, secondary at 0A0-0BF.
// [R11] Real-time clock and NMI mask at 070-07F.
// [R12] Port 0F0 clears coprocessor busy; port 0F1 resets coprocessor.
// [R13] Master input 2 carries secondary controller output for interrupts 8-15.
// [R14] Interrupt 9 serviced through vector 0AH.
// [R15] IRQ1 from keyboard output-buffer-full; IRQ0 from timer output 0.
// [R16] During DMA force address latch enable high and address enable active.
// [R17] Low 1MB decode true when unlatched address bits 23..20 are zero.
`timescale 1ns/100ps
`include "imcd_cfg.svh"
module imcd_top
  import imcd_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic cpu_mem_rd,
  input wire logic cpu_mem_wr,
  input wire logic cpu_io_cyc,
  input wire logic [9:0] cpu_io_addr,
  input wire logic cpu_ale,
  input wire logic [23:20] la_hi_in,
  input wire logic dma_active,
  input wire logic [`IMCD_NUM_DMA-1:0] dma_tc_reached,
  input wire logic ext_master_n,
  input wire logic mem_rd_n_in,
  input wire logic mem_wr_n_in,
  input wire logic timer_out0,
  input wire logic kbd_obf,
  input wire logic pic2_int,
  input wire logic [15:3] irq_in,
  output logic mem_rd_n_out,
  output logic mem_rd_n_oe_n,
  output logic mem_wr_n_out,
  output logic mem_wr_n_oe_n,
  output logic low_mem_rd_n,
  output logic low_mem_wr_n,
  output logic term_count,
  output logic addr_latch_en,
  output logic addr_en,
  output logic sel_pic1,
  output logic sel_pic2,
  output logic sel_rtc_nmi,
  output logic fpu_busy_clr,
  output logic fpu_reset,
  output logic [7:0] pic1_ir,
  output logic [7:0] pic2_ir,
  output logic [7:0] irq9_vector
);
  typedef struct packed {
    imcd_cyc_t cyc;
    logic oe_n;
    logic rd_n;
    logic wr_n;
    logic srd_n;
    logic swr_n;
    logic tc;
    logic tc_seen;
    logic ale;
    logic aen;
    logic [7:0] ir1;
    logic [7:0] ir2;
    logic [7:0] vec;
  } imcd_st_t;
  imcd_st_t st_q;
  imcd_st_t st_d;
  imcd_cyc_t req;
  logic low_mb;
  logic rd_act;
  logic wr_act;
  logic any_tc;

  imcd_if dbus ();

  ////////////////////////////////////////////////////////////////////////////
  assign dbus.io_addr = cpu_io_addr;
  assign dbus.io_cyc = cpu_io_cyc && !dma_active;

  imcd_io_dec u_dec (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .bus(dbus)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    low_mb = (la_hi_in == `IMCD_LOW_HI_BITS); // [R17]
    any_tc = |dma_tc_reached;

    // Board request; both at once is refused and drives neither strobe
    case ({cpu_mem_rd, cpu_mem_wr})
      2'b10: begin
        req = IMCD_READ;
      end
      2'b01: begin
        req = IMCD_WRITE;
      end
      2'b11: begin
        req = IMCD_IDLE;
      end
      default: begin
        req = IMCD_IDLE;
      end
    endcase

    // Our own request while we own the bus, else the sensed wire
    rd_act = !st_q.oe_n ? (req == IMCD_READ) : !mem_rd_n_in; // [R01]
    wr_act = !st_q.oe_n ? (req == IMCD_WRITE) : !mem_wr_n_in; // [R03]
    st_d = st_q;

    // Channel master takes the bus; our drivers let go
    st_d.oe_n = !ext_master_n; // [R07]
    if (rd_act) begin
      st_d.cyc = IMCD_READ;
    end else if (wr_act) begin
      st_d.cyc = IMCD_WRITE;
    end else begin
      st_d.cyc = IMCD_IDLE;
    end
    st_d.rd_n = !(ext_master_n && req == IMCD_READ); // [R01] [R08]
    st_d.wr_n = !(ext_master_n && req == IMCD_WRITE); // [R03] [R08]

    // Sub-1MB strobes always from us, derived from the kind of cycle seen
    case (st_d.cyc)
      IMCD_READ: begin
        st_d.srd_n = !low_mb; // [R02] [R08]
        st_d.swr_n = 1'b1;
      end
      IMCD_WRITE: begin
        st_d.srd_n = 1'b1;
        st_d.swr_n = !low_mb; // [R04] [R08]
      end
      IMCD_IDLE: begin
        st_d.srd_n = 1'b1;
        st_d.swr_n = 1'b1;
      end
      default: begin
        st_d.srd_n = 1'b1;
        st_d.swr_n = 1'b1;
      end
    endcase

    // Edge of the any-channel flag gives exactly one pulse per rise of that flag;
    // a channel that finishes while another still holds its flag is not seen
    st_d.tc_seen = any_tc;
    if (any_tc && !st_q.tc_seen) begin
      st_d.tc = 1'b1; // [R09]
    end else begin
      st_d.tc = 1'b0;
    end

    // DMA owns the address and command lines
    if (dma_active) begin
      st_d.ale = 1'b1; // [R16]
    end else begin
      st_d.ale = cpu_ale;
    end
    st_d.aen = dma_active; // [R16]

    st_d.ir1 = {irq_in[7:3], pic2_int, kbd_obf, timer_out0}; // [R13] [R15]
    // RTC source expected on the secondary's bit 0
    st_d.ir2 = {irq_in[15:9], irq_in[8]};
    st_d.vec = `IMCD_IRQ9_VEC; // [R14]
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st_q <= '{
        cyc: IMCD_IDLE,
        oe_n: 1'b0,
        rd_n: 1'b1,
        wr_n: 1'b1,
        srd_n: 1'b1,
        swr_n: 1'b1,
        tc: 1'b0,
        tc_seen: 1'b0,
        ale: 1'b0,
        aen: 1'b0,
        ir1: 8'h00,
        ir2: 8'h00,
        vec: `IMCD_IRQ9_VEC
      };
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared strobes and their enables
  assign mem_rd_n_out = st_q.rd_n;
  assign mem_rd_n_oe_n = st_q.oe_n; // [R07]
  assign mem_wr_n_out = st_q.wr_n;
  assign mem_wr_n_oe_n = st_q.oe_n; // [R07]

  // Sub-1MB strobes, terminal count and DMA controls
  assign low_mem_rd_n = st_q.srd_n;
  assign low_mem_wr_n = st_q.swr_n;
  assign term_count = st_q.tc;
  assign addr_latch_en = st_q.ale;
  assign addr_en = st_q.aen;

  // Decoder selects, already registered in the decoder
  assign sel_pic1 = dbus.sel_pic1;
  assign sel_pic2 = dbus.sel_pic2;
  assign sel_rtc_nmi = dbus.sel_rtc;
  assign fpu_busy_clr = dbus.fpu_clr;
  assign fpu_reset = dbus.fpu_rst;

  // Interrupt routing
  assign pic1_ir = st_q.ir1;
  assign pic2_ir = st_q.ir2;
  assign irq9_vector = st_q.vec;
endmodule : imcd_top

// File: imcd_cfg.svh
// Constants for the ISA memory command decode block
`ifndef IMCD_CFG_SVH
`define IMCD_CFG_SVH
`define IMCD_LOW_HI_BITS 4'h0
`define IMCD_PIC1_LO 10'h020
`define IMCD_PIC1_HI 10'h03f
`define IMCD_PIC2_LO 10'h0a0
`define IMCD_PIC2_HI 10'h0bf
`define IMCD_RTC_LO 10'h070
`define IMCD_RTC_HI 10'h07f
`define IMCD_FPU_CLR 10'h0f0
`define IMCD_FPU_RST 10'h0f1
`define IMCD_IRQ9_VEC 8'h0a
`define IMCD_CASCADE_IN 3'h2
`define IMCD_NUM_DMA 8
`endif

// File: imcd_pkg.sv
// Types for the ISA memory command decode block
package imcd_pkg;
  typedef enum logic [1:0] {
    IMCD_IDLE = 2'b00,
    IMCD_READ = 2'b01,
    IMCD_WRITE = 2'b10
  } imcd_cyc_t;
endpackage : imcd_pkg

// File: imcd_if.sv
// Carrier between the top module and the I/O decoder
`timescale 1ns/100ps
interface imcd_if;
  logic [9:0] io_addr;
  logic io_cyc;
  logic sel_pic1;
  logic sel_pic2;
  logic sel_rtc;
  logic fpu_clr;
  logic fpu_rst;
  modport dec (input io_addr, input io_cyc, output sel_pic1, output sel_pic2, output sel_rtc,
    output fpu_clr, output fpu_rst);
  modport top (output io_addr, output io_cyc, input sel_pic1, input sel_pic2, input sel_rtc,
    input fpu_clr, input fpu_rst);
endinterface : imcd_if

// File: imcd_io_dec.sv
// Registered fixed system I/O decode map
`timescale 1ns/100ps
`include "imcd_cfg.svh"
module imcd_io_dec
  import imcd_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  imcd_if.dec bus
);
  typedef struct packed {
    logic pic1;
    logic pic2;
    logic rtc;
    logic clr;
    logic rst;
  } imcd_dec_t;
  imcd_dec_t st_q;
  imcd_dec_t st_d;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_d.pic1 = bus.io_cyc && bus.io_addr >= `IMCD_PIC1_LO && bus.io_addr <= `IMCD_PIC1_HI; // [R10]
    st_d.pic2 = bus.io_cyc && bus.io_addr >= `IMCD_PIC2_LO && bus.io_addr <= `IMCD_PIC2_HI; // [R10]
    st_d.rtc = bus.io_cyc && bus.io_addr >= `IMCD_RTC_LO && bus.io_addr <= `IMCD_RTC_HI; // [R11]
    st_d.clr = bus.io_cyc && bus.io_addr == `IMCD_FPU_CLR; // [R12]
    st_d.rst = bus.io_cyc && bus.io_addr == `IMCD_FPU_RST; // [R12]
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign bus.sel_pic1 = st_q.pic1;
  assign bus.sel_pic2 = st_q.pic2;
  assign bus.sel_rtc = st_q.rtc;
  assign bus.fpu_clr = st_q.clr;
  assign bus.fpu_rst = st_q.rst;
endmodule : imcd_io_dec

// File: imcd_top_monitor.sv
// Port checker bound into the top module
`timescale 1ns/100ps
module imcd_top_monitor (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic cpu_mem_rd,
  input wire logic cpu_mem_wr,
  input wire logic ext_master_n,
  input wire logic dma_active,
  input wire logic [23:20] la_hi_in,
  input wire logic mem_rd_n_out,
  input wire logic mem_wr_n_out,
  input wire logic mem_rd_n_oe_n,
  input wire logic mem_wr_n_oe_n,
  input wire logic low_mem_rd_n,
  input wire logic low_mem_wr_n,
  input wire logic [7:0] dma_tc_reached,
  input wire logic term_count,
  input wire logic addr_en,
  input wire logic addr_latch_en,
  input wire logic cpu_io_cyc,
  input wire logic sel_pic1,
  input wire logic fpu_busy_clr,
  input wire logic [9:0] cpu_io_addr
);
  wire own_rd = cpu_mem_rd & ~cpu_mem_wr & ext_master_n;
  wire own_wr = cpu_mem_wr & ~cpu_mem_rd & ext_master_n;
  wire io_ok = cpu_io_cyc & ~dma_active;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  rd_strobe_a: assert property (own_rd |=> !mem_rd_n_out) else $error("rd");
  wr_strobe_a: assert property (own_wr |=> !mem_wr_n_out) else $error("wr");
  low_rd_a: assert property (!low_mem_rd_n |-> $past(la_hi_in) == 4'h0)
    else $error("lo");
  low_wr_a: assert property (!low_mem_wr_n |-> $past(la_hi_in) == 4'h0)
    else $error("low write");
  bus_free_a: assert property (!ext_master_n |=> mem_rd_n_oe_n && mem_wr_n_oe_n)
    else $error("oe");
  tc_pulse_a: assert property ($rose(|dma_tc_reached) |=> term_count ##1 !term_count)
    else $error("tc");
  dma_ctl_a: assert property (dma_active |=> addr_en && addr_latch_en)
    else $error("dma");
  pic1_sel_a: assert property (io_ok && cpu_io_addr inside {[10'h020:10'h03f]} |=> sel_pic1)
    else $error("pic");
  fpu_clr_a: assert property (io_ok && cpu_io_addr == 10'h0f0 |=> fpu_busy_clr)
    else $error("fpu");
  cover property (term_count);
  cover property (!low_mem_rd_n && mem_rd_n_oe_n);
  cover property (!low_mem_wr_n && mem_wr_n_oe_n);
  cover property (sel_pic1);
endmodule : imcd_top_monitor
bind imcd_top imcd_top_monitor u_imcd_top_monitor (
  .clk_sys(clk_sys),
  .resetn(resetn),
  .cpu_mem_rd(cpu_mem_rd),
  .cpu_mem_wr(cpu_mem_wr),
  .ext_master_n(ext_master_n),
  .dma_active(dma_active),
  .la_hi_in(la_hi_in),
  .mem_rd_n_out(mem_rd_n_out),
  .mem_wr_n_out(mem_wr_n_out),
  .mem_rd_n_oe_n(mem_rd_n_oe_n),
  .mem_wr_n_oe_n(mem_wr_n_oe_n),
  .low_mem_rd_n(low_mem_rd_n),
  .low_mem_wr_n(low_mem_wr_n),
  .dma_tc_reached(dma_tc_reached),
  .term_count(term_count),
  .addr_en(addr_en),
  .addr_latch_en(addr_latch_en),
  .cpu_io_cyc(cpu_io_cyc),
  .sel_pic1(sel_pic1),
  .fpu_busy_clr(fpu_busy_clr),
  .cpu_io_addr(cpu_io_addr)
);

// File: imcd_chan_master.sv
// Channel master model that borrows the bus for one memory cycle
`timescale 1ns/100ps
module imcd_chan_master (
  input wire logic clk_sys,
  output logic ext_master_n,
  output logic pm_rd,
  output logic pm_wr,
  output logic [23:20] pm_la
);
  initial {ext_master_n, pm_rd, pm_wr, pm_la} = 7'h7f;
  task automatic cycle(input logic rd, input logic [23:20] a, input int n);
    @(posedge clk_sys) ext_master_n <= 1'b0;
    @(posedge clk_sys) pm_la <= a;
    @(posedge clk_sys) {pm_rd, pm_wr} <= rd ? 2'b01 : 2'b10;
    repeat (n) @(posedge clk_sys);
    // Address lines float once released, so show the inverse, not a stale value
    {ext_master_n, pm_rd, pm_wr, pm_la} <= {3'b111, ~a};
  endtask : cycle
endmodule : imcd_chan_master

// File: tb.sv
// Self-checking bench for the memory command decode block
`timescale 1ns/100ps
module tb;
  logic clk_sys, resetn, cpu_mem_rd, cpu_mem_wr, cpu_io_cyc, cpu_ale, dma_active, timer_out0;
  logic kbd_obf, pic2_int, ext_master_n, pm_rd, pm_wr, mem_rd_n_in, mem_wr_n_in, fpu_reset;
  logic mem_rd_n_out, mem_rd_n_oe_n, mem_wr_n_out, mem_wr_n_oe_n, low_mem_rd_n, low_mem_wr_n;
  logic term_count, addr_latch_en, addr_en, sel_pic1, sel_pic2, sel_rtc_nmi, fpu_busy_clr;
  logic [9:0] cpu_io_addr;
  logic [23:20] la_hi_in, pm_la, cpu_la;
  logic [7:0] dma_tc_reached, pic1_ir, pic2_ir, irq9_vector;
  logic [15:3] irq_in;
  int miscompares = 0, tests_run = 0, cyc = 0;
  // Wired strobes: the enabled party drives, else the model
  assign mem_rd_n_in = !mem_rd_n_oe_n ? mem_rd_n_out : pm_rd;
  assign mem_wr_n_in = !mem_wr_n_oe_n ? mem_wr_n_out : pm_wr;
  assign la_hi_in = ext_master_n ? cpu_la : pm_la;
  imcd_top u_imcd_top (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .cpu_mem_rd(cpu_mem_rd),
    .cpu_mem_wr(cpu_mem_wr),
    .cpu_io_cyc(cpu_io_cyc),
    .cpu_io_addr(cpu_io_addr),
    .cpu_ale(cpu_ale),
    .la_hi_in(la_hi_in),
    .dma_active(dma_active),
    .dma_tc_reached(dma_tc_reached),
    .ext_master_n(ext_master_n),
    .mem_rd_n_in(mem_rd_n_in),
    .mem_wr_n_in(mem_wr_n_in),
    .timer_out0(timer_out0),
    .kbd_obf(kbd_obf),
    .pic2_int(pic2_int),
    .irq_in(irq_in),
    .mem_rd_n_out(mem_rd_n_out),
    .mem_rd_n_oe_n(mem_rd_n_oe_n),
    .mem_wr_n_out(mem_wr_n_out),
    .mem_wr_n_oe_n(mem_wr_n_oe_n),
    .low_mem_rd_n(low_mem_rd_n),
    .low_mem_wr_n(low_mem_wr_n),
    .term_count(term_count),
    .addr_latch_en(addr_latch_en),
    .addr_en(addr_en),
    .sel_pic1(sel_pic1),
    .sel_pic2(sel_pic2),
    .sel_rtc_nmi(sel_rtc_nmi),
    .fpu_busy_clr(fpu_busy_clr),
    .fpu_reset(fpu_reset),
    .pic1_ir(pic1_ir),
    .pic2_ir(pic2_ir),
    .irq9_vector(irq9_vector)
  );
  imcd_chan_master u_imcd_chan_master (
    .clk_sys(clk_sys),
    .ext_master_n(ext_master_n),
    .pm_rd(pm_rd),
    .pm_wr(pm_wr),
    .pm_la(pm_la)
  );
  initial begin
    clk_sys = 0;
    forever #5 clk_sys = ~clk_sys;
  end
  // The run needs about 80 cycles
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      miscompares++;
      end_sim();
    end
  end
  task automatic end_sim;
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [7:0] got, exp, input string m);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %0t %s", $time, m);
    end
  endtask : chk
  task automatic t_mem;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_sys) {cpu_mem_rd, cpu_mem_wr, cpu_la} <= {i[1:0], i[2], 3'h0};
      @(posedge clk_sys) #1;
      chk({mem_rd_n_out, mem_wr_n_out}, {i[1:0] != 2, i[1:0] != 1}, "cmd");
      chk({low_mem_rd_n, low_mem_wr_n}, {i != 2, i != 1}, "low");
    end
    @(posedge clk_sys) {cpu_mem_rd, cpu_mem_wr} <= 2'h0;
    $display("mem done");
  endtask : t_mem
  task automatic t_ext(input logic rd, input logic [23:20] a, input int n);
    fork
      u_imcd_chan_master.cycle(rd, a, n);
      begin
        @(negedge ext_master_n) @(posedge clk_sys) #1;
        chk({mem_rd_n_oe_n, mem_wr_n_oe_n}, 2'h3, "oe");
        @(negedge pm_rd or negedge pm_wr) @(posedge clk_sys) #1;
        chk(rd ? low_mem_rd_n : low_mem_wr_n, a != 0, "ext");
      end
    join
    $display("ext done");
  endtask : t_ext
  task automatic t_tc;
    @(posedge clk_sys) dma_tc_reached <= 8'h80;
    @(posedge clk_sys) dma_tc_reached <= 8'h81;
    #1 chk(term_count, 1, "tc");
    @(posedge clk_sys) dma_tc_reached <= 8'h00;
    #1 chk(term_count, 0, "tc1");
    @(posedge clk_sys) dma_tc_reached <= 8'h01;
    @(posedge clk_sys) #1 chk(term_count, 1, "tc2");
    $display("tc done");
  endtask : t_tc
  task automatic t_io;
    logic [9:0] a [8];
    logic [4:0] e;
    a = '{10'h01f, 10'h020, 10'h03f, 10'h07f, 10'h0a0, 10'h0bf, 10'h0f0, 10'h0f1};
    for (int j = 0; j < 16; j++) begin
      @(posedge clk_sys) {cpu_io_cyc, dma_active, cpu_ale, cpu_io_addr} <= {1'b1, j[3], j[0], a[j%8]};
      e = {a[j%8] inside {[10'h020:10'h03f]}, a[j%8] inside {[10'h0a0:10'h0bf]},
        a[j%8] inside {[10'h070:10'h07f]}, a[j%8] == 10'h0f0, a[j%8] == 10'h0f1};
      if (j > 7) e = 5'h0;
      @(posedge clk_sys) #1;
      chk({sel_pic1, sel_pic2, sel_rtc_nmi, fpu_busy_clr, fpu_reset}, e, "io");
      chk({addr_en, addr_latch_en}, {j[3], j[3] | j[0]}, "dma");
    end
    @(posedge clk_sys) {cpu_io_cyc, dma_active} <= 2'h0;
    $display("io done");
  endtask : t_io
  task automatic t_irq;
    @(posedge clk_sys) {irq_in, pic2_int, kbd_obf, timer_out0} <= 16'ha5c3;
    @(posedge clk_sys) #1;
    chk(pic1_ir, 8'hc3, "ir1");
    chk(pic2_ir, 8'ha5, "ir2");
    chk(irq9_vector, 8'h0a, "vec");
    // Second pattern raises the cascade input and drops timer and keyboard
    @(posedge clk_sys) {irq_in, pic2_int, kbd_obf, timer_out0} <= 16'h5a3c;
    @(posedge clk_sys) #1;
    chk(pic1_ir, 8'h3c, "ir1b");
    chk(pic2_ir, 8'h5a, "ir2b");
    $display("irq done");
  endtask : t_irq
  initial begin
    {cpu_mem_rd, cpu_mem_wr, cpu_io_cyc, cpu_ale, dma_active, timer_out0, kbd_obf} = '0;
    {pic2_int, cpu_io_addr, cpu_la, dma_tc_reached, irq_in, resetn} = '0;
    repeat (5) @(posedge clk_sys);
    resetn <= 1'b1;
    t_mem();
    t_ext(1'b1, 4'h0, 3);
    t_ext(1'b0, 4'h8, 1);
    t_ext(1'b0, 4'h0, 2);
    t_tc();
    t_io();
    t_irq();
    end_sim();
  end
endmodule : tb
